// ==== rtl/fthrb_defs.svh ====
`ifndef FTHRB_DEFS_SVH
`define FTHRB_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FTHRB_OFS_MIN_DUTY1     8'h64
`define FTHRB_OFS_MIN_DUTY2     8'h65
`define FTHRB_OFS_MIN_DUTY3     8'h66
`define FTHRB_OFS_START_R1      8'h67
`define FTHRB_OFS_START_LOC     8'h68
`define FTHRB_OFS_START_R2      8'h69
`define FTHRB_OFS_CRIT_R1       8'h6A
`define FTHRB_OFS_CRIT_LOC      8'h6B
`define FTHRB_OFS_CRIT_R2       8'h6C
`define FTHRB_OFS_HYST_R1_LOC   8'h6D
`define FTHRB_OFS_HYST_R2       8'h6E
`define FTHRB_OFS_TREE_TEST     8'h6F
`define FTHRB_OFS_OFFSET_R1     8'h70
`define FTHRB_OFS_OFFSET_LOC    8'h71
// Event registers
`define FTHRB_OFS_EVT_STATUS    8'hF0
`define FTHRB_OFS_EVT_CLEAR     8'hF1
`define FTHRB_OFS_EVT_ENABLE    8'hF2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FTHRB_RST_MIN_DUTY      8'h80
`define FTHRB_RST_START         8'h5A
`define FTHRB_RST_CRIT          8'h64
`define FTHRB_RST_HYST_R1_LOC   8'h44
`define FTHRB_RST_HYST_R2       8'h40
`define FTHRB_RST_ZERO          8'h00

// ----------------------------------------------------------------
// Field positions and special values
// ----------------------------------------------------------------
`define FTHRB_TREE_TEST_BIT     0
`define FTHRB_CRIT_DISABLED     8'h80
`define FTHRB_DUTY_FULL         8'hFF
`define FTHRB_EVT_CRIT_LSB      0
`define FTHRB_EVT_START_LSB     3
`define FTHRB_EVT_LOCK_DROP     6
`define FTHRB_EVT_AUTO_DROP     7

`endif

// ==== rtl/fthrb_pkg.sv ====
package fthrb_pkg;

  // Register bus request
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fthrb_bus_req_t;

  // Fan run state of one channel
  typedef enum logic {FTHRB_FAN_IDLE, FTHRB_FAN_RUN} fthrb_fan_st_t;

  // Critical override state of one channel
  typedef enum logic {FTHRB_CRIT_OFF, FTHRB_CRIT_ON} fthrb_crit_st_t;

endpackage

// ==== rtl/fthrb_top.sv ====
// Added by the designer: the strobed register port.
`include "fthrb_defs.svh"

module fthrb_top
  import fthrb_pkg::*;
#(
  parameter int NCH = 3
)
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Register port
  input  wire fthrb_bus_req_t        bus_req,
  output logic [7:0]                 bus_rdata,
  // Core configuration and readings
  input  wire logic                  cfg_lock,
  input  wire logic                  auto_fan_loop,
  input  wire logic                  overtemp_pin_is_out,
  input  wire logic [NCH-1:0][9:0]   temp_raw,
  input  wire logic [NCH-1:0][3:0]   temp_span,
  // Fan drive and status
  output logic [NCH-1:0][7:0]        duty_out,
  output logic                       force_full,
  output logic [NCH-1:0]             fan_active,
  output logic                       tree_test_enable,
  // Overtemp open-drain pin
  output logic                       overtemp_pin_o,
  output logic                       overtemp_pin_oe_n,
  // Interrupt
  output logic                       irq
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Add half-degree signed offset to quarter-degree reading, clamp
  function automatic logic [9:0] fthrb_apply_offset(input logic [9:0] raw, input logic [7:0] ofs);
    logic signed [11:0] sum;
    sum = $signed({2'b00, raw}) + $signed({{3{ofs[7]}}, ofs, 1'b0});
    if (sum < 0)
    begin
      return 10'h000;
    end
    if (sum > 12'sh3FF)
    begin
      return 10'h3FF;
    end
    return sum[9:0];
  endfunction

  // Level in quarter degrees minus hysteresis, may go negative
  function automatic logic signed [10:0] fthrb_lower(input logic [7:0] lvl, input logic [3:0] hy);
    return $signed({1'b0, lvl, 2'b00}) - $signed({5'b0_0000, hy, 2'b00});
  endfunction

  // Register write decode
  function automatic logic fthrb_hit(input logic [7:0] ofs);
    return bus_req.wr && (bus_req.addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [NCH-1:0][7:0] min_duty_r;
  logic [NCH-1:0][7:0] start_r;
  logic [NCH-1:0][7:0] crit_r;
  logic [7:0]          hyst_r1_loc_r;
  logic [7:0]          hyst_r2_r;
  logic                test_bit_r;
  logic [7:0]          ofs_r1_r;
  logic [7:0]          ofs_loc_r;
  logic [7:0]          evt_status_r;
  logic [7:0]          evt_enable_r;
  logic [7:0]          rdata_r;
  fthrb_fan_st_t       fan_st_r  [NCH];
  fthrb_fan_st_t       fan_st_nxt[NCH];
  fthrb_crit_st_t      crit_st_r [NCH];
  fthrb_crit_st_t      crit_st_nxt[NCH];
  logic [NCH-1:0][7:0] duty_r;
  logic [NCH-1:0][7:0] duty_nxt;
  logic                force_r;
  logic                pin_oe_n_r;
  logic                irq_r;

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  // Locked range covers start temperatures through local offset
  wire lock_range = (bus_req.addr >= `FTHRB_OFS_START_R1) && (bus_req.addr <= `FTHRB_OFS_OFFSET_LOC);
  wire min_range  = (bus_req.addr >= `FTHRB_OFS_MIN_DUTY1) && (bus_req.addr <= `FTHRB_OFS_MIN_DUTY3);
  wire wr_min_ok  = bus_req.wr && min_range && !auto_fan_loop;
  wire wr_lck_ok  = !cfg_lock;
  wire drop_lock  = bus_req.wr && lock_range && cfg_lock;
  wire drop_auto  = bus_req.wr && min_range && auto_fan_loop;
  wire [1:0] min_idx = 2'(bus_req.addr - `FTHRB_OFS_MIN_DUTY1);

  // ----------------------------------------------------------------
  // Channel fields and corrected temperatures
  // ----------------------------------------------------------------
  wire [NCH-1:0][3:0] hyst_f;
  wire [NCH-1:0][9:0] temp_corr;

  // Remote 1 upper nibble, local lower nibble, remote 2 upper nibble
  assign hyst_f[0] = hyst_r1_loc_r[7:4];
  assign hyst_f[1] = hyst_r1_loc_r[3:0];
  assign hyst_f[2] = hyst_r2_r[7:4];

  // Remote 2 arrives already corrected by the core
  assign temp_corr[0] = fthrb_apply_offset(temp_raw[0], ofs_r1_r);
  assign temp_corr[1] = fthrb_apply_offset(temp_raw[1], ofs_loc_r);
  assign temp_corr[2] = temp_raw[2];

  // ----------------------------------------------------------------
  // Per-channel compares
  // ----------------------------------------------------------------
  wire [NCH-1:0] above_start;
  wire [NCH-1:0] below_start_low;
  wire [NCH-1:0] above_crit;
  wire [NCH-1:0] below_crit_low;
  wire [NCH-1:0] crit_off;
  wire [NCH-1:0] pin_trip;
  wire [NCH-1:0][7:0] ch_duty;

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    wire signed [10:0] t_s     = $signed({1'b0, temp_corr[c]});
    wire [9:0]         start_q = {start_r[c], 2'b00};
    wire [9:0]         excess  = (temp_corr[c] > start_q) ? temp_corr[c] - start_q : 10'h000;
    wire [11:0]        inc     = excess[9:2] * temp_span[c];
    wire [12:0]        dsum    = 13'(min_duty_r[c]) + 13'(inc);

    // Comparisons use offset-corrected values
    assign above_start[c]     = temp_corr[c] > start_q;
    assign below_start_low[c] = t_s <= fthrb_lower(start_r[c], hyst_f[c]);
    assign crit_off[c]        = crit_r[c] == `FTHRB_CRIT_DISABLED;
    assign above_crit[c]      = temp_corr[c] > {crit_r[c], 2'b00};
    assign below_crit_low[c]  = t_s < fthrb_lower(crit_r[c], hyst_f[c]);
    // More than one quarter-degree step past the limit trips the pin
    assign pin_trip[c]        = !crit_off[c] && (temp_corr[c] > 10'({crit_r[c], 2'b00} + 10'h001));
    // Min duty plus span-scaled excess, saturating at full
    assign ch_duty[c]         = (dsum > 13'h00FF) ? `FTHRB_DUTY_FULL : dsum[7:0];
  end

  // ----------------------------------------------------------------
  // Channel state machines
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      fan_st_nxt[c]  = fan_st_r[c];
      crit_st_nxt[c] = crit_st_r[c];
      unique case (fan_st_r[c])
        FTHRB_FAN_IDLE:
        begin
          if (above_start[c])
          begin
            fan_st_nxt[c] = FTHRB_FAN_RUN;
          end
        end
        FTHRB_FAN_RUN:
        begin
          if (below_start_low[c])
          begin
            fan_st_nxt[c] = FTHRB_FAN_IDLE;
          end
        end
      endcase
      // A disabled limit drops any override in flight
      unique case (crit_st_r[c])
        FTHRB_CRIT_OFF:
        begin
          if (above_crit[c] && !crit_off[c])
          begin
            crit_st_nxt[c] = FTHRB_CRIT_ON;
          end
        end
        FTHRB_CRIT_ON:
        begin
          if (crit_off[c] || below_crit_low[c])
          begin
            crit_st_nxt[c] = FTHRB_CRIT_OFF;
          end
        end
      endcase
    end
  end

  // Override forces every duty output, whatever channel tripped
  wire force_nxt = (crit_st_nxt[0] == FTHRB_CRIT_ON) || (crit_st_nxt[1] == FTHRB_CRIT_ON)
                   || (crit_st_nxt[2] == FTHRB_CRIT_ON);

  // Duty from next state so outputs and state agree in one cycle
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (force_nxt)
      begin
        duty_nxt[c] = `FTHRB_DUTY_FULL;
      end
      else if (auto_fan_loop && fan_st_nxt[c] == FTHRB_FAN_RUN)
      begin
        duty_nxt[c] = ch_duty[c];
      end
      else
      begin
        duty_nxt[c] = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  wire [2:0] evt_crit;
  wire [2:0] evt_start;
  for (genvar c = 0; c < NCH; c++)
  begin : g_evt
    assign evt_crit[c]  = crit_st_r[c] == FTHRB_CRIT_OFF && crit_st_nxt[c] == FTHRB_CRIT_ON;
    assign evt_start[c] = fan_st_r[c] == FTHRB_FAN_IDLE && fan_st_nxt[c] == FTHRB_FAN_RUN;
  end
  wire [7:0] evt_set = {drop_auto, drop_lock, evt_start, evt_crit};
  wire [7:0] evt_clr = fthrb_hit(`FTHRB_OFS_EVT_CLEAR) ? bus_req.wdata : 8'h00;
  // Set beats clear so no event is lost in the clearing cycle
  wire [7:0] evt_nxt = (evt_status_r & ~evt_clr) | evt_set;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (bus_req.addr)
      `FTHRB_OFS_MIN_DUTY1:   rd_mux = min_duty_r[0];
      `FTHRB_OFS_MIN_DUTY2:   rd_mux = min_duty_r[1];
      `FTHRB_OFS_MIN_DUTY3:   rd_mux = min_duty_r[2];
      `FTHRB_OFS_START_R1:    rd_mux = start_r[0];
      `FTHRB_OFS_START_LOC:   rd_mux = start_r[1];
      `FTHRB_OFS_START_R2:    rd_mux = start_r[2];
      `FTHRB_OFS_CRIT_R1:     rd_mux = crit_r[0];
      `FTHRB_OFS_CRIT_LOC:    rd_mux = crit_r[1];
      `FTHRB_OFS_CRIT_R2:     rd_mux = crit_r[2];
      `FTHRB_OFS_HYST_R1_LOC: rd_mux = hyst_r1_loc_r;
      `FTHRB_OFS_HYST_R2:     rd_mux = hyst_r2_r;
      `FTHRB_OFS_TREE_TEST:   rd_mux = {7'h00, test_bit_r};
      `FTHRB_OFS_OFFSET_R1:   rd_mux = ofs_r1_r;
      `FTHRB_OFS_OFFSET_LOC:  rd_mux = ofs_loc_r;
      `FTHRB_OFS_EVT_STATUS:  rd_mux = evt_status_r;
      `FTHRB_OFS_EVT_ENABLE:  rd_mux = evt_enable_r;
      default:                rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Minimum duty, frozen while automatic control runs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      min_duty_r <= {NCH{`FTHRB_RST_MIN_DUTY}};
    end
    else if (wr_min_ok && min_idx < 2'(NCH))
    begin
      min_duty_r[min_idx] <= bus_req.wdata;
    end
  end

  // Lock-protected bank
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_r       <= {NCH{`FTHRB_RST_START}};
      crit_r        <= {NCH{`FTHRB_RST_CRIT}};
      hyst_r1_loc_r <= `FTHRB_RST_HYST_R1_LOC;
      hyst_r2_r     <= `FTHRB_RST_HYST_R2;
      test_bit_r    <= 1'b0;
      ofs_r1_r      <= `FTHRB_RST_ZERO;
      ofs_loc_r     <= `FTHRB_RST_ZERO;
    end
    else if (wr_lck_ok)
    begin
      if (fthrb_hit(`FTHRB_OFS_START_R1))    start_r[0]    <= bus_req.wdata;
      if (fthrb_hit(`FTHRB_OFS_START_LOC))   start_r[1]    <= bus_req.wdata;
      if (fthrb_hit(`FTHRB_OFS_START_R2))    start_r[2]    <= bus_req.wdata;
      if (fthrb_hit(`FTHRB_OFS_CRIT_R1))     crit_r[0]     <= bus_req.wdata;
      if (fthrb_hit(`FTHRB_OFS_CRIT_LOC))    crit_r[1]     <= bus_req.wdata;
      if (fthrb_hit(`FTHRB_OFS_CRIT_R2))     crit_r[2]     <= bus_req.wdata;
      if (fthrb_hit(`FTHRB_OFS_HYST_R1_LOC)) hyst_r1_loc_r <= bus_req.wdata;
      if (fthrb_hit(`FTHRB_OFS_HYST_R2))     hyst_r2_r     <= bus_req.wdata;
      // Only the enable bit is stored; upper bits read zero
      if (fthrb_hit(`FTHRB_OFS_TREE_TEST))   test_bit_r    <= bus_req.wdata[`FTHRB_TREE_TEST_BIT];
      if (fthrb_hit(`FTHRB_OFS_OFFSET_R1))   ofs_r1_r      <= bus_req.wdata;
      if (fthrb_hit(`FTHRB_OFS_OFFSET_LOC))  ofs_loc_r     <= bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // State, outputs and event registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        fan_st_r[c]  <= FTHRB_FAN_IDLE;
        crit_st_r[c] <= FTHRB_CRIT_OFF;
      end
      duty_r       <= '0;
      force_r      <= 1'b0;
      pin_oe_n_r   <= 1'b1;
      evt_status_r <= 8'h00;
      evt_enable_r <= 8'h00;
      irq_r        <= 1'b0;
      rdata_r      <= 8'h00;
    end
    else
    begin
      fan_st_r     <= fan_st_nxt;
      crit_st_r    <= crit_st_nxt;
      duty_r       <= duty_nxt;
      force_r      <= force_nxt;
      pin_oe_n_r   <= !(overtemp_pin_is_out && (|pin_trip));
      evt_status_r <= evt_nxt;
      if (fthrb_hit(`FTHRB_OFS_EVT_ENABLE))
      begin
        evt_enable_r <= bus_req.wdata;
      end
      irq_r        <= |(evt_nxt & evt_enable_r);
      // Read data stands only in the cycle after the strobe
      rdata_r      <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  // Outputs straight from flops; pin is pull-down only
  assign bus_rdata         = rdata_r;
  assign duty_out          = duty_r;
  assign force_full        = force_r;
  assign tree_test_enable  = test_bit_r;
  assign overtemp_pin_o    = 1'b0;
  assign overtemp_pin_oe_n = pin_oe_n_r;
  assign irq               = irq_r;
  for (genvar c = 0; c < NCH; c++)
  begin : g_act
    assign fan_active[c] = fan_st_r[c] == FTHRB_FAN_RUN;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_MIN_FROZEN_AUTO: assert property (bus_req.wr && min_range && auto_fan_loop |=> $stable(min_duty_r))
    else $error("min duty changed during automatic control");
  AST_MIN_WRITE_TAKES: assert property (bus_req.wr && bus_req.addr == `FTHRB_OFS_MIN_DUTY1
    && !auto_fan_loop |=> min_duty_r[0] == $past(bus_req.wdata))
    else $error("min duty write not stored");
  AST_LOCK_FREEZES: assert property (cfg_lock |=> $stable(start_r) && $stable(crit_r)
    && $stable(ofs_r1_r) && $stable(ofs_loc_r) && $stable(hyst_r1_loc_r) && $stable(test_bit_r))
    else $error("locked register changed");
  AST_FORCE_FULL: assert property (crit_st_r[1] == FTHRB_CRIT_ON |-> force_full && duty_out[0] == 8'hFF
    && duty_out[2] == 8'hFF)
    else $error("override did not force full duty");
  AST_CRIT_DISABLED: assert property (crit_r[2] == 8'h80 |=> crit_st_r[2] == FTHRB_CRIT_OFF)
    else $error("disabled limit still overriding");
  AST_CRIT_HOLD: assert property (crit_st_r[1] == FTHRB_CRIT_ON && !crit_off[1] && !below_crit_low[1]
    |=> crit_st_r[1] == FTHRB_CRIT_ON)
    else $error("override left before limit minus hysteresis");
  AST_PIN_TRIP: assert property (overtemp_pin_is_out && (|pin_trip) |=> !overtemp_pin_oe_n)
    else $error("overtemp pin not asserted");
  AST_PIN_IDLE: assert property (!overtemp_pin_is_out |=> overtemp_pin_oe_n)
    else $error("overtemp pin driven while configured as input");
  AST_START_RUN: assert property (above_start[0] |=> fan_active[0])
    else $error("fan did not start above start temperature");
  AST_HYST_HOLD: assert property (fan_active[1] && !below_start_low[1] |=> fan_active[1])
    else $error("fan stopped inside hysteresis band");
  AST_TEST_BIT: assert property (bus_req.wr && bus_req.addr == `FTHRB_OFS_TREE_TEST && !cfg_lock
    |=> tree_test_enable == $past(bus_req.wdata[0]) ##1 $stable(tree_test_enable) || bus_req.wr)
    else $error("test bit not taken");
  AST_OFFSET_APPLIED: assert property (ofs_r1_r == 8'hFC && temp_raw[0] == 10'h150 |-> temp_corr[0] == 10'h148)
    else $error("remote 1 offset not applied");

  COV_CRIT_ENTRY: cover property (crit_st_r[1] == FTHRB_CRIT_OFF ##1 crit_st_r[1] == FTHRB_CRIT_ON);
  COV_FAN_CYCLE:  cover property (fan_active[1] ##[1:50] !fan_active[1]);
  COV_LOCK_DROP:  cover property (drop_lock ##1 evt_status_r[`FTHRB_EVT_LOCK_DROP]);
  COV_IRQ:        cover property (!irq ##1 irq);

endmodule

// ==== tb/fthrb_host_model.sv ====
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module fthrb_host_model
  import fthrb_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Register port
  output fthrb_bus_req_t  bus_req,
  input  wire logic [7:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial bus_req = '0;

  // One-cycle write; released fields show junk so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req <= '{~a, ~d, 1'b0, 1'b0};
  endtask

  // One-cycle read; data is taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req <= '{~a, 8'hFF, 1'b0, 1'b0};
    #1;
    d = bus_rdata;
  endtask
endmodule

// ==== tb/testbench.sv ====
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))

module testbench
  import fthrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic            clk_sys = 1'b0;
  logic            rst_n = 1'b0;
  fthrb_bus_req_t  bus_req;
  logic [7:0]      bus_rdata;
  logic            cfg_lock = 1'b0;
  logic            auto_fan_loop = 1'b0;
  logic            pin_out = 1'b1;
  logic [2:0][9:0] temp_raw = {3{10'h100}};
  logic [2:0][3:0] temp_span = {3{4'h3}};
  logic [2:0][7:0] duty_out;
  logic            force_full;
  logic [2:0]      fan_active;
  logic            tree_test_enable;
  logic            oe_n;
  logic            pin_o;
  logic            irq;
  logic [7:0]      rv;
  int              n_errors = 0;
  int              comparisons = 0;
  int              cycles = 0;
  localparam logic [7:0] RST [14] = '{8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A, 8'h64,
                                      8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00};

  always #5 clk_sys = ~clk_sys;

  fthrb_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cfg_lock(cfg_lock), .auto_fan_loop(auto_fan_loop), .overtemp_pin_is_out(pin_out),
    .temp_raw(temp_raw), .temp_span(temp_span), .duty_out(duty_out), .force_full(force_full),
    .fan_active(fan_active), .tree_test_enable(tree_test_enable), .overtemp_pin_o(pin_o),
    .overtemp_pin_oe_n(oe_n), .irq(irq));

  fthrb_host_model u_host (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rdata(bus_rdata));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rv);
    `CHK(n, e, rv);
  endtask

  // New reading, then two edges for the registered outputs to follow
  task automatic temp(input int ch, input logic [9:0] t);
    @(posedge clk_sys);
    temp_raw[ch] <= t;
    tick(2);
  endtask

  // Hang guard: under two hundred cycles are expected
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      summarize();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 14; i++)
      rchk("reset value", 8'(8'h64 + i), RST[i]);
    rchk("unmapped", 8'h80, 8'h00);
    u_host.wr(8'h67, 8'h50);
    rchk("start r1", 8'h67, 8'h50);
    u_host.wr(8'h6F, 8'h01);
    tick(2);
    `CHK("test on", 1, tree_test_enable);
    u_host.wr(8'h6F, 8'h00);
    tick(2);
    `CHK("test off", 0, tree_test_enable);
    u_host.wr(8'h64, 8'h00);
    rchk("duty off", 8'h64, 8'h00);
    u_host.wr(8'h64, 8'h80);
    // Min duty frozen once the automatic loop runs
    auto_fan_loop <= 1'b1;
    u_host.wr(8'h64, 8'h10);
    rchk("duty frozen", 8'h64, 8'h80);
    u_host.rd(8'hF0, rv);
    `CHK("auto drop evt", 8'h80, rv & 8'h80);
    // Remote 1: start 0x50, hysteresis 4, span 3
    temp(0, 10'h148);
    `CHK("fan run", 9'h186, {fan_active[0], duty_out[0]});
    temp(0, 10'h138);
    `CHK("fan hold", 9'h180, {fan_active[0], duty_out[0]});
    temp(0, 10'h130);
    `CHK("fan stop", 0, fan_active[0]);
    u_host.wr(8'h70, 8'hFC);
    temp(0, 10'h144);
    `CHK("offset below", 0, fan_active[0]);
    temp(0, 10'h150);
    `CHK("offset run", 9'h186, {fan_active[0], duty_out[0]});
    temp(0, 10'h100);
    // Remote 2 override disabled, local override with +1 degree offset
    u_host.wr(8'h6C, 8'h80);
    temp(2, 10'h3FF);
    `CHK("crit disabled", 0, force_full);
    temp(2, 10'h100);
    u_host.wr(8'h71, 8'h02);
    u_host.wr(8'h6D, 8'h46);
    temp(1, 10'h18D);
    `CHK("crit on", 26'h3FFFFFF, {force_full, oe_n, duty_out});
    temp(1, 10'h18E);
    `CHK("pin low", 0, {pin_o, oe_n});
    @(posedge clk_sys);
    pin_out <= 1'b0;
    tick(2);
    `CHK("pin as input", 1, oe_n);
    temp(1, 10'h174);
    `CHK("crit hold", 1, force_full);
    temp(1, 10'h173);
    `CHK("crit off", 0, force_full);
    // Masked status, then enable, then clear
    `CHK("irq masked", 0, irq);
    u_host.wr(8'hF2, 8'h80);
    tick(2);
    `CHK("irq on", 1, irq);
    u_host.wr(8'hF1, 8'hFF);
    tick(2);
    `CHK("irq cleared", 0, irq);
    rchk("status clear", 8'hF0, 8'h00);
    // Lock freezes the threshold set
    u_host.wr(8'hF2, 8'h40);
    cfg_lock <= 1'b1;
    u_host.wr(8'h67, 8'h33);
    u_host.wr(8'h6F, 8'h01);
    rchk("start locked", 8'h67, 8'h50);
    `CHK("lock", 3'b100, {irq, tree_test_enable, force_full});
    summarize();
  end
endmodule
